/* File: pdr_map.svh */
// offsets, field positions, reset values and timing counts of the pulse dialer
`ifndef PDR_MAP_SVH
`define PDR_MAP_SVH
`define PDR_CLK_HZ 100000000
`define PDR_OSC_HZ 2400
`define PDR_FAST_FACTOR 100
`define PDR_CTRL_OFS 12'h000
`define PDR_STAT_OFS 12'h004
`define PDR_CTRL_CLR_BIT 0
`define PDR_CTRL_HOLD_BIT 1
`define PDR_CTRL_RST 1'b0
`define PDR_STAT_WR_LSB 0
`define PDR_STAT_RD_LSB 8
`define PDR_STAT_FLAG_LSB 16
`define PDR_PER10_MS 100
`define PDR_PER20_MS 50
`define PDR_BRK_HI_PM 666
`define PDR_BRK_LO_PM 600
`define PDR_IDP_MS 800
`define PDR_MO_MS 10
`define PDR_OH_MS 300
`define PDR_KD_MS 17
`define PDR_MS2TICK(ms) ((((ms) * `PDR_OSC_HZ) + 999) / 1000)
`define PDR_PER10_TICKS `PDR_MS2TICK(`PDR_PER10_MS)
`define PDR_PER20_TICKS `PDR_MS2TICK(`PDR_PER20_MS)
`define PDR_IDP_TICKS `PDR_MS2TICK(`PDR_IDP_MS)
`define PDR_MO_TICKS `PDR_MS2TICK(`PDR_MO_MS)
`define PDR_OH_TICKS `PDR_MS2TICK(`PDR_OH_MS)
`define PDR_KD_SCANS ((`PDR_MS2TICK(`PDR_KD_MS) + 1) / 2)
`define PDR_MEM_DEPTH 32
`define PDR_KEY_STAR 4'h9
`define PDR_KEY_ZERO 4'ha
`define PDR_KEY_HASH 4'hb
`endif

/* File: pdr_pkg.sv */
// types of the pulse dialer
package pdr_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PAUSE = 3'b001,
        ST_BREAK = 3'b010,
        ST_MAKE = 3'b011,
        ST_OVERLAP = 3'b100
    } pdr_dial_t;

    typedef struct packed {
        pdr_dial_t st;
        logic [10:0] timer;
        logic [3:0] pulses;
        logic [5:0] rd;
        logic [5:0] wr;
        logic mem_valid;
        logic first_key;
        logic redial_ok;
        logic fast;
        logic onhook;
        logic [9:0] hold_cnt;
        logic hold_done;
        logic [15:0] div;
        logic [15:0] fdiv;
        logic key_active;
        logic scan_ph;
        logic col_ok;
        logic [1:0] col_idx;
        logic [3:0] key_code;
        logic [4:0] deb;
        logic locked;
        logic hold_dial;
        logic [31:0] prdata;
        logic mute_oe_n;
        logic pulse_oe_n;
        logic kp_hi;
        logic [3:0] row_oe_n;
        logic [2:0] col_oe_n;
    } pdr_state_t;
endpackage

/* File: pdr_pulse_dialer.sv */
// pulse dialer with redial memory, keypad scanner and apb status port
// Functional notes
// - pulse rate 10 pps with rate select low, 20 pps with it high.
// - make/break 33.4/66.6 with select high, 40/60 with it low.
// - mute goes active at start of each predigit pause, held through dialing.
// - mute stays active an overlap time after the final break ends.
// - hook input low means off-hook, high means on-hook.
// - going on-hook mid-dial sends remaining digits 100x faster, 50/50.
// - after fast outpulsing the block idles; only memory and clear survive.
// - returning off-hook gives a falling edge on the mute output.
// - star or hash as first key redials the stored sequence.
// - any other first key clears memory, then stores and dials new digits.
// - line pulse pin open during make, pulled low during break.
// - on-hook stops the oscillator once the 300 ms hold time and any outpulsing end, and ignores all keys.
// - off-hook, one pressed key is detected and its code stored.
// - memory holds 32 digits and buffers keys entered faster than dialed.
// - pulsing continues until every stored digit has been dialed.
// - redial only allowed after at least 300 ms on-hook.
// - power-up clear invalidates stored digits, blocking redial of garbage.
// - a key is valid only as exactly one row with exactly one column.
// - on-hook, rows and columns are held high and no key is taken.
// - keypad static until a key shows, then rows and columns scanned alternately.
`include "pdr_map.svh"

module pdr_pulse_dialer
    import pdr_pkg::*;
#(
    parameter int OSC_DIV = `PDR_CLK_HZ / `PDR_OSC_HZ
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hook_state_in,
    input wire logic dial_rate_select,
    input wire logic make_break_select,
    input wire logic [3:0] keypad_row_inputs,
    output logic [3:0] keypad_row_drive,
    output logic [3:0] keypad_row_oe_n,
    input wire logic [2:0] keypad_column_inputs,
    output logic [2:0] keypad_column_drive,
    output logic [2:0] keypad_column_oe_n,
    input wire logic line_pulse_sense,
    output logic line_pulse_drive,
    output logic line_pulse_oe_n,
    input wire logic mute_sense,
    output logic mute_drive,
    output logic mute_oe_n
);
    localparam int FAST_DIV = OSC_DIV / `PDR_FAST_FACTOR;
    localparam int DEB_SCANS = `PDR_KD_SCANS;
    localparam int FAST_HALF10 = `PDR_PER10_TICKS / 2;
    localparam int FAST_HALF20 = `PDR_PER20_TICKS / 2;

    pdr_state_t s;
    pdr_state_t n;
    logic [3:0] digit_mem [0:`PDR_MEM_DEPTH-1];
    logic osc_run;
    logic osc_tick;
    logic fast_tick;
    logic t_tick;
    logic t_done;
    logic acc;
    logic sh;
    logic row_ok;
    logic [1:0] row_idx;
    logic [3:0] code;
    logic sw_clear;
    logic apb_access;
    logic apb_hit;
    logic mem_we;
    logic [4:0] mem_wa;
    logic [3:0] mem_wd;
    logic [31:0] status;

    // returns {exactly one bit set, index of the set bit}
    function automatic logic [2:0] low_one(input logic [3:0] lo);
        logic [1:0] idx;
        idx = 2'd0;
        for (int i = 0; i < 4; i++)
            if (lo[i])
                idx = 2'(i);
        low_one = {$onehot(lo), idx};
    endfunction

    // break or make timer load, one less than its length in ticks; the fast mode splits the period evenly
    function automatic logic [10:0] pulse_len(input logic r20, input logic mb,
                                              input logic f, input logic brk);
        int per;
        int b;
        per = r20 ? `PDR_PER20_TICKS : `PDR_PER10_TICKS;
        b = (per * (mb ? `PDR_BRK_HI_PM : `PDR_BRK_LO_PM) + 500) / 1000;
        if (f)
            b = per / 2;
        pulse_len = brk ? 11'(b - 1) : 11'(per - b - 1);
    endfunction

    function automatic logic [3:0] key_pulses(input logic [3:0] k);
        key_pulses = (k == `PDR_KEY_ZERO) ? 4'd10 : 4'(k + 4'd1);
    endfunction

    always_comb
    begin
        n = s;
        acc = 1'b0;
        row_ok = 1'b0;
        row_idx = 2'd0;
        code = 4'd0;
        sw_clear = 1'b0;
        mem_we = 1'b0;
        mem_wa = 5'd0;
        mem_wd = 4'd0;
        n.onhook = hook_state_in;
        // the divider runs only while something needs time
        osc_run = (s.st != ST_IDLE) || (s.onhook ? !s.hold_done : s.key_active);
        osc_tick = osc_run && (s.div == 16'(OSC_DIV - 1));
        fast_tick = osc_run && (s.fdiv == 16'(FAST_DIV - 1));
        t_tick = s.fast ? fast_tick : osc_tick;
        t_done = t_tick && (s.timer == 11'd0);
        n.div = (!osc_run || osc_tick) ? 16'd0 : 16'(s.div + 16'd1);
        n.fdiv = (!osc_run || fast_tick) ? 16'd0 : 16'(s.fdiv + 16'd1);
        if (t_tick && s.timer != 11'd0)
            n.timer = 11'(s.timer - 11'd1);

        // hook handling and on-hook hold timer
        if (s.onhook)
        begin
            n.key_active = 1'b0;
            n.locked = 1'b0;
            n.deb = 5'd0;
            if (osc_tick && !s.hold_done)
            begin
                n.hold_cnt = 10'(s.hold_cnt + 10'd1);
                if (s.hold_cnt == 10'(`PDR_OH_TICKS - 1))
                    n.hold_done = 1'b1;
            end
            if (!hook_state_in)
            begin
                n.redial_ok = s.hold_done;
                n.first_key = 1'b1;
                n.hold_cnt = 10'd0;
                n.hold_done = 1'b0;
                n.fast = 1'b0;
            end
            if (s.st != ST_IDLE)
                n.fast = hook_state_in;
        end
        else if (!s.key_active)
        begin
            // rows held low, columns float: any low column wakes the scanner
            if (!(&keypad_column_inputs))
            begin
                n.key_active = 1'b1;
                n.scan_ph = 1'b0;
            end
        end
        else if (osc_tick)
        begin
            if (!s.scan_ph)
            begin
                {n.col_ok, n.col_idx} = low_one({1'b1, keypad_column_inputs} ^ 4'hf);
                n.scan_ph = 1'b1;
            end
            else
            begin
                n.scan_ph = 1'b0;
                {row_ok, row_idx} = low_one(~keypad_row_inputs);
                code = 4'({2'b00, row_idx} * 4'd3 + {2'b00, s.col_idx});
                if (s.col_ok && row_ok)
                begin
                    if (code != s.key_code)
                    begin
                        n.key_code = code;
                        n.deb = 5'd0;
                        n.locked = 1'b0;
                    end
                    else if (s.deb != 5'(DEB_SCANS - 1))
                        n.deb = 5'(s.deb + 5'd1);
                    else if (!s.locked)
                    begin
                        acc = 1'b1;
                        n.locked = 1'b1;
                    end
                end
                else
                begin
                    n.deb = 5'd0;
                    // a bounce resets the count; full release returns to static
                    if (&keypad_row_inputs && !s.col_ok)
                    begin
                        n.key_active = 1'b0;
                        n.locked = 1'b0;
                    end
                end
            end
        end

        // apb registers
        apb_access = psel && penable && clk_en;
        apb_hit = (paddr == `PDR_CTRL_OFS) || (paddr == `PDR_STAT_OFS);
        status = {7'h00, mute_sense, line_pulse_sense, s.redial_ok, s.mem_valid, s.fast,
                  !s.pulse_oe_n, !s.mute_oe_n, s.st != ST_IDLE, !s.onhook,
                  2'b00, s.rd, 2'b00, s.wr};
        if (psel && !penable)
        begin
            if (paddr == `PDR_CTRL_OFS)
                n.prdata = {30'h0000_0000, s.hold_dial, 1'b0};
            else if (paddr == `PDR_STAT_OFS)
                n.prdata = status;
            else
                n.prdata = 32'h0000_0000;
        end
        if (apb_access && pwrite && pstrb[0] && paddr == `PDR_CTRL_OFS)
        begin
            n.hold_dial = pwdata[`PDR_CTRL_HOLD_BIT];
            sw_clear = pwdata[`PDR_CTRL_CLR_BIT];
        end
        if (sw_clear)
        begin
            n.mem_valid = 1'b0;
            n.wr = 6'd0;
            n.rd = 6'd0;
        end

        // key acceptance; a new digit wins over a clear in the same cycle
        sh = (s.key_code == `PDR_KEY_STAR) || (s.key_code == `PDR_KEY_HASH);
        if (acc)
        begin
            n.first_key = 1'b0;
            if (s.first_key && sh)
            begin
                if (s.redial_ok && s.mem_valid && s.st == ST_IDLE)
                    n.rd = 6'd0;
            end
            else if (s.first_key)
            begin
                mem_we = 1'b1;
                mem_wa = 5'd0;
                n.wr = 6'd1;
                n.rd = 6'd0;
                n.mem_valid = 1'b1;
            end
            else if (!sh && n.wr != 6'(`PDR_MEM_DEPTH))
            begin
                mem_we = 1'b1;
                mem_wa = n.wr[4:0];
                n.wr = 6'(n.wr + 6'd1);
                n.mem_valid = 1'b1;
            end
            mem_wd = key_pulses(s.key_code);
        end

        // outpulsing
        case (s.st)
            ST_IDLE:
            begin
                if (s.onhook && !hook_state_in)
                begin
                    n.st = ST_OVERLAP;
                    n.timer = 11'(`PDR_MO_TICKS - 1);
                end
                else if (s.rd < s.wr && !s.hold_dial && !s.onhook)
                begin
                    n.st = ST_PAUSE;
                    n.timer = 11'(`PDR_IDP_TICKS - 1);
                end
                else if (s.onhook)
                    n.fast = 1'b0;
            end
            ST_PAUSE:
                if (t_done)
                begin
                    n.pulses = digit_mem[s.rd[4:0]];
                    n.rd = 6'(s.rd + 6'd1);
                    n.st = ST_BREAK;
                    n.timer = pulse_len(dial_rate_select, make_break_select, n.fast, 1'b1);
                end
            ST_BREAK:
                if (t_done)
                begin
                    n.pulses = 4'(s.pulses - 4'd1);
                    if (s.pulses == 4'd1 && s.rd >= s.wr)
                    begin
                        n.st = ST_OVERLAP;
                        n.timer = 11'(`PDR_MO_TICKS - 1);
                    end
                    else
                    begin
                        n.st = ST_MAKE;
                        n.timer = pulse_len(dial_rate_select, make_break_select, n.fast, 1'b0);
                    end
                end
            ST_MAKE:
                if (t_done)
                begin
                    if (s.pulses != 4'd0)
                    begin
                        n.st = ST_BREAK;
                        n.timer = pulse_len(dial_rate_select, make_break_select, n.fast, 1'b1);
                    end
                    else
                    begin
                        n.st = ST_PAUSE;
                        n.timer = 11'(`PDR_IDP_TICKS - 1);
                    end
                end
            ST_OVERLAP:
                if (t_done)
                    n.st = ST_IDLE;
            default:
                n.st = ST_IDLE;
        endcase

        // pin drive, registered with the state
        n.mute_oe_n = (n.st == ST_IDLE);
        n.pulse_oe_n = (n.st != ST_BREAK);
        n.kp_hi = n.onhook;
        if (n.onhook)
        begin
            // drop the scanner on the same edge the hook goes high, not one later
            n.key_active = 1'b0;
            n.row_oe_n = 4'h0;
            n.col_oe_n = 3'h0;
        end
        else if (n.key_active && n.scan_ph)
        begin
            n.row_oe_n = 4'hf;
            n.col_oe_n = 3'h0;
        end
        else
        begin
            n.row_oe_n = 4'h0;
            n.col_oe_n = 3'h7;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
            s.onhook <= 1'b1;
            s.mute_oe_n <= 1'b1;
            s.pulse_oe_n <= 1'b1;
            s.kp_hi <= 1'b1;
            s.hold_dial <= `PDR_CTRL_RST;
        end
        else if (clk_en)
            s <= n;
    end

    // digit memory has no reset; validity is tracked separately
    always_ff @(posedge pclk)
    begin
        if (clk_en && mem_we)
            digit_mem[mem_wa] <= mem_wd;
    end

    assign prdata = s.prdata;
    assign pready = clk_en;
    assign pslverr = apb_access && !apb_hit;
    assign keypad_row_drive = {4{s.kp_hi}};
    assign keypad_row_oe_n = s.row_oe_n;
    assign keypad_column_drive = {3{s.kp_hi}};
    assign keypad_column_oe_n = s.col_oe_n;
    assign line_pulse_drive = 1'b0;
    assign line_pulse_oe_n = s.pulse_oe_n;
    assign mute_drive = 1'b0;
    assign mute_oe_n = s.mute_oe_n;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence last_brk;
        s.st == ST_BREAK ##1 s.st == ST_OVERLAP;
    endsequence
    sequence pause_to_brk;
        s.st == ST_PAUSE ##1 s.st == ST_BREAK;
    endsequence

    chk_onhook_pins: assert property (s.onhook |-> keypad_row_oe_n == 4'h0 && keypad_row_drive == 4'hf && !s.key_active)
        else $error("keypad not held high on-hook");
    chk_break_muted: assert property (!line_pulse_oe_n |-> !mute_oe_n)
        else $error("break outside mute");
    chk_mute_overlap: assert property (last_brk |-> !mute_oe_n && line_pulse_oe_n && s.rd == s.wr)
        else $error("mute released at final break");
    chk_pulse_load: assert property (pause_to_brk |-> s.pulses inside {[4'd1:4'd10]})
        else $error("bad pulse count");
    chk_mem_bound: assert property (s.wr <= 6'd32 && s.rd <= s.wr)
        else $error("memory pointers out of range");
    chk_fast_half: assert property (s.st == ST_BREAK && $past(s.st) == ST_PAUSE && s.fast
        |-> int'(s.timer) == ($past(dial_rate_select) ? FAST_HALF20 : FAST_HALF10) - 1)
        else $error("fast break not half period");
    chk_break_len: assert property (s.st == ST_BREAK && $past(s.st) != ST_BREAK && !s.fast
        |-> s.timer == ($past(dial_rate_select) ? ($past(make_break_select) ? 11'h04f : 11'h047)
        : ($past(make_break_select) ? 11'h09f : 11'h08f)))
        else $error("normal break length wrong");
    chk_fast_onhook: assert property (s.fast |-> s.onhook)
        else $error("fast mode off-hook");
    chk_offhook_mute: assert property ($fell(s.onhook) |-> !mute_oe_n)
        else $error("no mute edge at off-hook");
    chk_redial_start: assert property (clk_en && acc && s.first_key && sh && s.redial_ok
        && s.mem_valid && s.st == ST_IDLE |=> s.rd == 6'd0 && s.wr == $past(s.wr))
        else $error("redial did not restart");
    chk_no_redial: assert property (clk_en && acc && sh && !s.redial_ok && s.st == ST_IDLE
        |=> s.rd == $past(s.rd) && s.wr == $past(s.wr))
        else $error("redial without hold time");
    chk_new_number: assert property (clk_en && acc && s.first_key && !sh |=> s.wr == 6'd1 && s.mem_valid)
        else $error("new number not stored");
    chk_powerup_clear: assert property (!s.mem_valid |-> s.wr == 6'd0)
        else $error("digits kept while invalid");
    chk_osc_stop: assert property (s.onhook && s.hold_done && s.st == ST_IDLE |-> !osc_run)
        else $error("oscillator running on-hook");
endmodule // pdr_pulse_dialer

/* File: pdr_keypad_model.sv */
// keypad, line and mute pin model standing outside the pulse dialer
module pdr_keypad_model (
    input wire logic [3:0] row_drive,
    input wire logic [3:0] row_oe_n,
    input wire logic [2:0] col_drive,
    input wire logic [2:0] col_oe_n,
    input wire logic key_down,
    input wire logic [1:0] key_row,
    input wire logic [1:0] key_col,
    output logic [3:0] row_lvl,
    output logic [2:0] col_lvl,
    input wire logic line_drive,
    input wire logic line_oe_n,
    output logic line_sense,
    input wire logic mute_drive,
    input wire logic mute_oe_n,
    output logic mute_sense
);
    timeunit 1ns;
    timeprecision 1ps;
    logic shared;
    always_comb
    begin
        // released pins float up through the pull-ups
        for (int i = 0; i < 4; i++)
            row_lvl[i] = row_oe_n[i] ? 1'b1 : row_drive[i];
        for (int j = 0; j < 3; j++)
            col_lvl[j] = col_oe_n[j] ? 1'b1 : col_drive[j];
        // one contact joins one row to one column, low wins on contention
        shared = row_lvl[key_row] & col_lvl[key_col];
        if (key_down)
        begin
            row_lvl[key_row] = shared;
            col_lvl[key_col] = shared;
        end
        line_sense = line_oe_n ? 1'b1 : line_drive;
        mute_sense = mute_oe_n ? 1'b1 : mute_drive;
    end
endmodule // pdr_keypad_model

/* File: pulse_dialer_redial_tb.sv */
// self-checking bench of the pulse dialer: keys, hook, fast outpulsing, redial
module pulse_dialer_redial_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hf;
    logic hook = 1'b1;
    logic rate_sel = 1'b0;
    logic mbs = 1'b1;
    logic key_down = 1'b0;
    logic [1:0] key_row = 2'h0;
    logic [1:0] key_col = 2'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, line_drive, line_oe_n, line_sense, mute_drive, mute_oe_n;
    logic mute_sense, mute_prev;
    logic [3:0] row_drive, row_oe_n, row_lvl;
    logic [2:0] col_drive, col_oe_n, col_lvl;
    int miscompares = 0;
    int samples_checked = 0;
    int brk_cnt = 0, brk_len = 0, mk_len = 0, ovl = 0, run_lo = 0, run_hi = 0;

    always #5 pclk = ~pclk;

    // oscillator divider shortened so a tick is 100 pclk cycles and a fast tick is 1
    pdr_pulse_dialer #(.OSC_DIV(100)) DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hook_state_in(hook), .dial_rate_select(rate_sel), .make_break_select(mbs),
        .keypad_row_inputs(row_lvl), .keypad_row_drive(row_drive),
        .keypad_row_oe_n(row_oe_n), .keypad_column_inputs(col_lvl),
        .keypad_column_drive(col_drive), .keypad_column_oe_n(col_oe_n),
        .line_pulse_sense(line_sense), .line_pulse_drive(line_drive),
        .line_pulse_oe_n(line_oe_n), .mute_sense(mute_sense), .mute_drive(mute_drive),
        .mute_oe_n(mute_oe_n));

    pdr_keypad_model keypad (.row_drive(row_drive), .row_oe_n(row_oe_n),
        .col_drive(col_drive), .col_oe_n(col_oe_n), .key_down(key_down),
        .key_row(key_row), .key_col(key_col), .row_lvl(row_lvl), .col_lvl(col_lvl),
        .line_drive(line_drive), .line_oe_n(line_oe_n), .line_sense(line_sense),
        .mute_drive(mute_drive), .mute_oe_n(mute_oe_n), .mute_sense(mute_sense));

    // pulse timing seen at the pins, sampled mid-cycle to stay clear of the edge
    always @(negedge pclk)
    begin
        if (mute_oe_n === 1'b1 && mute_prev === 1'b0)
            ovl = run_hi;
        mute_prev = mute_oe_n;
        if (line_oe_n === 1'b0)
        begin
            if (run_hi != 0 && brk_cnt != 0)
                mk_len = run_hi;
            run_lo++;
            run_hi = 0;
        end
        else
        begin
            if (run_lo != 0)
            begin
                brk_cnt++;
                brk_len = run_lo;
            end
            run_lo = 0;
            run_hi++;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_mute(input logic lvl, input int lim);
        int n;
        n = 0;
        while (mute_oe_n !== lvl && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
        if (mute_oe_n !== lvl)
        begin
            $display("[FAIL] t=%0t mute wait timed out got=%h exp=%h", $time, mute_oe_n, lvl);
            miscompares++;
        end
    endtask

    // hold the key until dialing starts, as a real user does
    task automatic key_dial(input logic [1:0] r, input logic [1:0] c);
        @(posedge pclk);
        key_row <= r;
        key_col <= c;
        key_down <= 1'b1;
        wait_mute(1'b0, 8000);
        check(mute_oe_n, 1'b0);
        key_down <= 1'b0;
    endtask

    task automatic hang_up_fast(input int exp_len);
        @(posedge pclk);
        brk_cnt = 0;
        hook <= 1'b1;
        wait_mute(1'b1, 6000);
        check(brk_cnt, 2);
        check(brk_len, exp_len);
        check(mk_len, exp_len);
        check(ovl, 24);
    endtask

    task automatic go_off_hook();
        @(posedge pclk);
        hook <= 1'b0;
        wait_mute(1'b0, 300);
        check(mute_oe_n, 1'b0);
        wait_mute(1'b1, 3000);
    endtask

    task automatic t_reset_regs();
        check({row_oe_n, row_drive, col_oe_n, col_drive}, {4'h0, 4'hf, 3'h0, 3'h7});
        check({line_oe_n, mute_oe_n}, 2'b11);
        apb(1'b0, 12'h000, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(1'b1, 12'h000, 32'h0000_0002);
        apb(1'b0, 12'h000, 32'h0000_0000);
        check(rd, 32'h0000_0002);
        apb(1'b1, 12'h000, 32'h0000_0000);
        apb(1'b0, 12'h008, 32'h0000_0000);
        check({err, rd}, {1'b1, 32'h0000_0000});
        $display("test reset_regs done");
    endtask

    task automatic t_star_after_clear();
        go_off_hook();
        key_row <= 2'h3;
        key_col <= 2'h0;
        key_down <= 1'b1;
        repeat (6000) @(posedge pclk);
        key_down <= 0;
        check({mute_oe_n, line_oe_n}, 2'b11);
        apb(1'b0, 12'h004, 32'h0000_0000);
        check({rd[22:21], rd[5:0]}, 8'h00);
        $display("test star_after_clear done");
    endtask

    task automatic t_dial_fast();
        // a short hang-up makes the next key the first one again
        @(posedge pclk);
        hook <= 1'b1;
        repeat (4) @(posedge pclk);
        go_off_hook();
        key_dial(2'h0, 2'h1);
        apb(1'b0, 12'h004, 32'h0000_0000);
        check({rd[16], rd[5:0]}, {1'b1, 6'h01});
        hang_up_fast(120);
        $display("test dial_fast done");
    endtask

    task automatic t_redial();
        repeat (71000) @(posedge pclk);
        go_off_hook();
        rate_sel <= 1'b1;
        mbs <= 1'b0;
        key_dial(2'h3, 2'h2);
        hang_up_fast(60);
        apb(1'b1, 12'h000, 32'h0000_0001);
        apb(1'b0, 12'h004, 32'h0000_0000);
        check({rd[21], rd[5:0]}, 7'h00);
        $display("test redial done");
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_regs();
        t_star_after_clear();
        t_dial_fast();
        t_redial();
        stop_test();
    end

    // whole run is about 100k cycles; this leaves a third more before giving up
    initial
    begin
        #1_300_000;
        miscompares++;
        stop_test();
    end
endmodule // pulse_dialer_redial_tb
